// *** design/psd_params.svh ***
// register offsets, reset values, field positions and widths
`ifndef PSD_PARAMS_SVH
`define PSD_PARAMS_SVH
`define PSD_OFS_SHUTDOWN 4'h0
`define PSD_OFS_DEADBAND 4'h4
`define PSD_OFS_STEER    4'h8
`define PSD_OFS_MODE     4'hC
`define PSD_RST_SHUTDOWN 8'h00
`define PSD_RST_DEADBAND 8'h00
`define PSD_RST_STEER    8'h01
`define PSD_RST_MODE     8'h00
`define PSD_BIT_EVENT    7
`define PSD_STEER_WMASK  8'hDF
`define PSD_MODE_WMASK   8'hCF
`define PSD_SRC_OFF      3'h0
`define PSD_DB_WIDTH     7
`endif

// *** design/psd_pkg.sv ***
// types of the pwm shutdown, dead-band and steering stage
package psd_pkg;
    typedef enum logic [1:0] {
        PSD_BR_SINGLE   = 2'b00,
        PSD_BR_FULL_FWD = 2'b01,
        PSD_BR_HALF     = 2'b10,
        PSD_BR_FULL_REV = 2'b11
    } psd_bridge_type;

    typedef struct packed {
        logic       shutdown_event_status;
        logic [2:0] shutdown_source_select;
        logic [1:0] pair_ac_shutdown_state;
        logic [1:0] pair_bd_shutdown_state;
    } psd_shutdown_type;

    typedef struct packed {
        logic       auto_restart_enable;
        logic [6:0] dead_band_count;
    } psd_deadband_type;

    typedef struct packed {
        logic [1:0] complementary_pair_select;
        logic       unused_zero;
        logic       steering_sync;
        logic [3:0] steer_enable;
    } psd_steer_type;

    typedef struct packed {
        psd_bridge_type bridge_output_mode_bits;
        logic [1:0]     spare;
        logic [3:0]     capture_compare_mode_bits;
    } psd_mode_type;
endpackage

// *** design/psd_top.sv ***
// pwm output stage: auto-shutdown, restart, dead-band and pulse steering
//
// Contract
// - source select picks shutdown triggers, 000 off
// - firmware setting event bit causes shutdown
// - event bit one means outputs shut down
// - event bit sticky until firmware or restart
// - shutdown forces enabled pins without clock
// - pair a/c shutdown: low, high, tristate
// - pair b/d shutdown: low, high, tristate
// - shutdown condition is level, not edge
// - event bit writes ignored while condition present
// - output resumes at next period start
// - auto restart clears event bit when gone
// - half-bridge delays only inactive-to-active edges
// - dead-band count in cycles, bits 6-0
// - steering only in single output mode
// - steer enables route pwm or release pin
// - mode low bits set steered polarity
// - steering sync defers change to period
// - pair select makes a plus b, c, d
// - shutdown touches only enabled pwm pins
// - steering bit 5 reads zero
// - count above duty keeps output inactive
// - unsynced steering change may truncate waveform
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`include "psd_params.svh"

module psd_top
    import psd_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        pwm_waveform_in,
    input  wire logic        period_start_in,
    input  wire logic        fault_input_pin_n_in,
    input  wire logic        comparator_one_output_in,
    input  wire logic        comparator_two_output_in,
    output logic      [3:0]  pwm_pins_out,
    output logic      [3:0]  pwm_pins_oe_out
);

    localparam int DBW = `PSD_DB_WIDTH;

    psd_shutdown_type sd_q;
    logic [6:0]       cfg_q;
    logic             ev_q;
    psd_deadband_type db_q;
    psd_steer_type    st_q;
    psd_mode_type     md_q;
    logic             ack_q;
    logic [31:0]      rdata_q;
    logic [7:0]       rd_mux;
    logic             wr_fire;
    logic             wr_sd;
    logic             fw_set;
    logic             sd_cond;
    logic             hold_q;
    logic             shut_now;
    logic             shut_out;
    logic [5:0]       steer_eff_q;
    logic [1:0]       db_in;
    logic [1:0]       db_out;
    logic [DBW-1:0]   db_cnt_q [2];
    logic [3:0]       act;
    logic [3:0]       en;
    logic [3:0]       level;
    logic [3:0]       norm_q;
    logic [3:0]       en_q;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        return a == o;
    endfunction

    // one hit per source bit covers all eight select codes
    function automatic logic src_hit(input logic [2:0] s, input logic c1,
                                     input logic c2, input logic flt_n);
        return (s[0] & c1) | (s[1] & c2) | (s[2] & ~flt_n);
    endfunction

    // ---------------- avalon slave: one wait state per access
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    assign avs_readdata_out    = rdata_q;
    assign wr_fire = avs_write_in & ack_q & avs_byteenable_in[0];
    assign wr_sd   = wr_fire & hit(avs_address_in, `PSD_OFS_SHUTDOWN);
    assign fw_set  = wr_sd & avs_writedata_in[`PSD_BIT_EVENT];

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        if (hit(avs_address_in, `PSD_OFS_SHUTDOWN)) begin
            rd_mux = sd_q;
        end else if (hit(avs_address_in, `PSD_OFS_DEADBAND)) begin
            rd_mux = db_q;
        end else if (hit(avs_address_in, `PSD_OFS_STEER)) begin
            rd_mux = st_q & `PSD_STEER_WMASK;
        end else if (hit(avs_address_in, `PSD_OFS_MODE)) begin
            rd_mux = md_q;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_in & ~ack_q) begin
            rdata_q <= {24'h00_0000, rd_mux};
        end
    end

    // ---------------- configuration registers
    // the event bit lives in its own flop so each part has one writer
    assign sd_q = {ev_q, cfg_q};

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_q <= 7'(`PSD_RST_SHUTDOWN);
        end else if (wr_sd) begin
            cfg_q <= avs_writedata_in[6:0];
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            db_q <= `PSD_RST_DEADBAND;
            st_q <= `PSD_RST_STEER;
            md_q <= `PSD_RST_MODE;
        end else if (wr_fire) begin
            if (hit(avs_address_in, `PSD_OFS_DEADBAND)) begin
                db_q <= avs_writedata_in[7:0];
            end
            if (hit(avs_address_in, `PSD_OFS_STEER)) begin
                st_q <= avs_writedata_in[7:0] & `PSD_STEER_WMASK;
            end
            if (hit(avs_address_in, `PSD_OFS_MODE)) begin
                md_q <= avs_writedata_in[7:0] & `PSD_MODE_WMASK;
            end
        end
    end

    // ---------------- shutdown condition and event status
    assign sd_cond = src_hit(sd_q.shutdown_source_select,
                             comparator_one_output_in,
                             comparator_two_output_in,
                             fault_input_pin_n_in);

    // set beats every clear; a clear write is dropped while sources hold
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ev_q <= 1'(`PSD_RST_SHUTDOWN >> `PSD_BIT_EVENT);
        end else if (sd_cond | fw_set) begin
            ev_q <= 1'b1;
        end else if (db_q.auto_restart_enable) begin
            ev_q <= 1'b0;
        end else if (wr_sd) begin
            ev_q <= 1'b0;
        end
    end

    assign shut_now = sd_cond | sd_q.shutdown_event_status;

    // pins stay shut after the clear until the next period begins
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_q <= 1'b0;
        end else if (shut_now) begin
            hold_q <= 1'b1;
        end else if (period_start_in) begin
            hold_q <= 1'b0;
        end
    end

    assign shut_out = shut_now | hold_q;

    // ---------------- steering update point
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            steer_eff_q <= 6'h01;
        end else if (!st_q.steering_sync || period_start_in) begin
            steer_eff_q <= {st_q.complementary_pair_select,
                            st_q.steer_enable};
        end
    end

    // ---------------- dead-band on the two half-bridge outputs
    assign db_in = {~pwm_waveform_in, pwm_waveform_in};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_db
            // only the rising edge waits; a fall clears the count at once
            assign db_out[i] = db_in[i] &
                (db_cnt_q[i] >= db_q.dead_band_count);
            always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    db_cnt_q[i] <= '0;
                end else if (!db_in[i]) begin
                    db_cnt_q[i] <= '0;
                end else if (db_cnt_q[i] < db_q.dead_band_count) begin
                    db_cnt_q[i] <= DBW'(db_cnt_q[i] + 1'b1);
                end
            end
        end
    endgenerate

    // ---------------- output mode and steering
    always_comb begin
        act = 4'h0;
        en  = 4'h0;
        case (md_q.bridge_output_mode_bits)
            PSD_BR_SINGLE: begin
                act = {4{pwm_waveform_in}};
                if (steer_eff_q[5:4] != 2'b00) begin
                    en = 4'h1;
                    en[steer_eff_q[5:4]] = 1'b1;
                    act[steer_eff_q[5:4]] = ~pwm_waveform_in;
                end else begin
                    en = steer_eff_q[3:0];
                end
            end
            PSD_BR_HALF: begin
                en  = 4'h3;
                act = {2'b00, db_out};
            end
            PSD_BR_FULL_FWD: begin
                en  = 4'hF;
                act = {pwm_waveform_in, 3'b001};
            end
            PSD_BR_FULL_REV: begin
                en  = 4'hF;
                act = {2'b01, pwm_waveform_in, 1'b0};
            end
            default: begin
                en  = 4'h0;
                act = 4'h0;
            end
        endcase
        if (md_q.capture_compare_mode_bits[3:2] != 2'b11) begin
            en = 4'h0;
        end
    end

    // bit 1 inverts pins a and c, bit 0 inverts pins b and d
    assign level = act ^ {md_q.capture_compare_mode_bits[0],
                          md_q.capture_compare_mode_bits[1],
                          md_q.capture_compare_mode_bits[0],
                          md_q.capture_compare_mode_bits[1]};

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            norm_q <= 4'h0;
            en_q   <= 4'h0;
        end else begin
            norm_q <= level & en;
            en_q   <= en;
        end
    end

    // shutdown override is combinational so it needs no clock edge
    generate
        for (genvar p = 0; p < 4; p++) begin : g_pin
            logic [1:0] st;
            assign st = (p % 2 == 1) ? sd_q.pair_bd_shutdown_state
                             : sd_q.pair_ac_shutdown_state;
            always_comb begin
                if (en_q[p] && shut_out) begin
                    pwm_pins_oe_out[p] = ~st[1];
                    pwm_pins_out[p]    = ~st[1] & st[0];
                end else begin
                    pwm_pins_oe_out[p] = en_q[p];
                    pwm_pins_out[p]    = norm_q[p];
                end
            end
        end
    endgenerate

    // ---------------- assertions
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    AST_SRC_OFF: assert property (
        sd_q.shutdown_source_select == `PSD_SRC_OFF |-> !sd_cond)
        else $error("disabled source select still raised shutdown");

    AST_FW_SET: assert property (
        fw_set |=> sd_q.shutdown_event_status ##0 shut_out)
        else $error("firmware set of event bit did not shut down");

    AST_STATUS_SHUT: assert property (
        sd_q.shutdown_event_status && en_q[0] && !sd_q.pair_ac_shutdown_state[1]
        |-> pwm_pins_out[0] == sd_q.pair_ac_shutdown_state[0])
        else $error("event bit set but pin a not in shutdown state");

    AST_STICKY: assert property (
        sd_q.shutdown_event_status && !db_q.auto_restart_enable && !wr_sd
        |=> sd_q.shutdown_event_status)
        else $error("event bit cleared without firmware or restart");

    AST_ASYNC_AC: assert property (
        sd_cond && en_q[2]
        |-> pwm_pins_oe_out[2] == !sd_q.pair_ac_shutdown_state[1])
        else $error("pin c not forced in the cycle of the fault");

    AST_BD_TRI: assert property (
        shut_out && en_q[3] && sd_q.pair_bd_shutdown_state[1]
        |-> !pwm_pins_oe_out[3] && !pwm_pins_oe_out[1] | !en_q[1])
        else $error("b/d pair not tristated in shutdown");

    AST_LEVEL_HOLD: assert property (
        sd_cond[*2] |=> sd_q.shutdown_event_status && hold_q)
        else $error("persistent level did not keep shutdown");

    AST_WRITE_IGNORED: assert property (
        sd_cond && wr_sd && !avs_writedata_in[7]
        |=> sd_q.shutdown_event_status)
        else $error("clear write took effect during shutdown");

    AST_RESUME_AT_PERIOD: assert property (
        $fell(hold_q) |-> $past(period_start_in) && !$past(shut_now))
        else $error("output resumed away from a period start");

    AST_AUTO_CLEAR: assert property (
        sd_q.shutdown_event_status && db_q.auto_restart_enable
        && !sd_cond && !fw_set |=> !sd_q.shutdown_event_status)
        else $error("auto restart did not clear event bit");

    AST_DB_DELAY: assert property (
        $rose(pwm_waveform_in) && db_q.dead_band_count >= 7'h02
        && md_q.bridge_output_mode_bits == PSD_BR_HALF
        |-> !db_out[0] ##1 (!db_out[0] || !pwm_waveform_in))
        else $error("dead-band shorter than programmed count");

    AST_STEER_SYNC: assert property (
        st_q.steering_sync && !period_start_in |=> $stable(steer_eff_q))
        else $error("synced steering changed away from period start");

    AST_BIT5_ZERO: assert property (
        avs_read_in && ack_q && hit(avs_address_in, `PSD_OFS_STEER)
        |-> !avs_readdata_out[5])
        else $error("steering bit 5 read back as one");

    AST_AC_DRIVE_HIGH: assert property (
        shut_out && en_q[2] && sd_q.pair_ac_shutdown_state == 2'b01
        |-> pwm_pins_out[2] && pwm_pins_oe_out[2])
        else $error("pin c not driven high in shutdown");

    AST_ONLY_ENABLED: assert property (
        shut_out && !en_q[1] |-> !pwm_pins_oe_out[1])
        else $error("shutdown drove pin b although it carries no pwm");

    COV_AUTO_RESTART: cover property (
        sd_cond ##1 !sd_cond && db_q.auto_restart_enable ##[1:50]
        $fell(hold_q));
    COV_FW_SHUTDOWN: cover property (fw_set ##1 shut_out);
    COV_DB_ACTIVE: cover property (
        db_q.dead_band_count != 7'h00 ##0 $rose(db_out[0]));
    COV_STEER_SYNC: cover property (
        st_q.steering_sync && period_start_in ##1 $changed(steer_eff_q));

endmodule

// *** tb/psd_switch_model.sv ***
// model of the external switch drivers hanging on the four pwm pins
`timescale 1ns/10ps
module psd_switch_model (
    input  wire logic [3:0] pin_in,
    input  wire logic [3:0] oe_in,
    output logic      [3:0] level_out
);
    // a released pin falls to the pull-down that keeps its switch off;
    // it never keeps showing the last driven value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            level_out[i] = oe_in[i] ? pin_in[i] : 1'b0;
        end
    end
endmodule

// *** tb/pwm_shutdown_deadband_steering_test.sv ***
// self-checking bench for the pwm shutdown, dead-band and steering stage
`timescale 1ns/10ps
`include "psd_params.svh"
module pwm_shutdown_deadband_steering_test;
    logic        clk, rst, rd, wr, pwm, ps, flt_n, c1, c2, hit;
    logic [3:0]  addr, pins, oe, lvl;
    logic [31:0] wdata, rdata;
    logic        wait_req;
    logic [7:0]  q, sd;
    logic [1:0]  mb;
    int          n_mismatch, checks_done, dr0, df0, dr3, df3;

    psd_top DUT (
        .core_clk_in              (clk),
        .sys_rst_in               (rst),
        .avs_address_in           (addr),
        .avs_read_in              (rd),
        .avs_write_in             (wr),
        .avs_writedata_in         (wdata),
        .avs_byteenable_in        (4'hF),
        .avs_readdata_out         (rdata),
        .avs_waitrequest_out      (wait_req),
        .pwm_waveform_in          (pwm),
        .period_start_in          (ps),
        .fault_input_pin_n_in     (flt_n),
        .comparator_one_output_in (c1),
        .comparator_two_output_in (c2),
        .pwm_pins_out             (pins),
        .pwm_pins_oe_out          (oe)
    );

    psd_switch_model switches (
        .pin_in    (pins),
        .oe_in     (oe),
        .level_out (lvl)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic wrap_up();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // one access; the request stands until an edge samples waitrequest
    // low, read data is taken at that same edge and only then released
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge clk);
        rd    <= ~w;
        wr    <= w;
        addr  <= a;
        wdata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                n_mismatch++;
                wrap_up();
            end
        end while (wait_req !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic look(input logic [3:0] el, input logic [3:0] eo);
        #1;
        chk({4'h0, lvl}, {4'h0, el});
        chk({4'h0, oe}, {4'h0, eo});
    endtask

    task automatic restart();
        @(posedge clk) ps <= 1'b1;
        @(posedge clk) ps <= 1'b0;
        cyc(1);
    endtask

    // cycles from a pwm change until pin a shows the same level
    task automatic edge_time(input logic v, output int d);
        @(posedge clk) pwm <= v;
        d = 0;
        #1;
        while (lvl[0] !== v && d < 40) begin
            @(posedge clk);
            #1;
            d++;
        end
        if (lvl[0] !== v) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        pwm = 1'b0;
        ps = 1'b0;
        flt_n = 1'b1;
        c1 = 1'b0;
        c2 = 1'b0;
        n_mismatch = 0;
        checks_done = 0;
        cyc(5);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 4'(i * 4), 8'h00);
            chk(q, (i == 2) ? 8'h01 : 8'h00);
        end
        bus(1'b1, 4'h6, 8'h5A);
        bus(1'b0, 4'h6, 8'h00);
        chk(q, 8'h00);
        bus(1'b1, `PSD_OFS_STEER, 8'hFF);
        bus(1'b0, `PSD_OFS_STEER, 8'h00);
        chk(q, 8'hDF);
        bus(1'b1, `PSD_OFS_STEER, 8'h0F);
        bus(1'b1, `PSD_OFS_DEADBAND, 8'h80);
        bus(1'b1, `PSD_OFS_MODE, 8'h0C);
        pwm <= 1'b1;
        cyc(3);
        look(4'hF, 4'hF);
        // every source code against every source; pair a/c low, b/d high
        for (int code = 0; code < 8; code++) begin
            for (int s = 0; s < 3; s++) begin
                sd = {1'b0, 3'(code), 4'h1};
                hit = 1'((code >> s) & 1);
                bus(1'b1, `PSD_OFS_SHUTDOWN, sd);
                c1 <= (s == 0);
                c2 <= (s == 1);
                flt_n <= (s != 2);
                look(hit ? 4'hA : 4'hF, 4'hF);
                bus(1'b0, `PSD_OFS_SHUTDOWN, 8'h00);
                chk(q, {hit, sd[6:0]});
                look(hit ? 4'hA : 4'hF, 4'hF);
                @(posedge clk);
                c1 <= 1'b0;
                c2 <= 1'b0;
                flt_n <= 1'b1;
                cyc(3);
                bus(1'b0, `PSD_OFS_SHUTDOWN, 8'h00);
                chk(q, sd);
                look(hit ? 4'hA : 4'hF, 4'hF);
                restart();
                look(4'hF, 4'hF);
            end
        end
        // without auto restart only software brings the outputs back
        bus(1'b1, `PSD_OFS_DEADBAND, 8'h00);
        bus(1'b1, `PSD_OFS_SHUTDOWN, 8'h11);
        c1 <= 1'b1;
        cyc(2);
        bus(1'b1, `PSD_OFS_SHUTDOWN, 8'h11);
        bus(1'b0, `PSD_OFS_SHUTDOWN, 8'h00);
        chk(q, 8'h91);
        c1 <= 1'b0;
        cyc(3);
        bus(1'b0, `PSD_OFS_SHUTDOWN, 8'h00);
        chk(q, 8'h91);
        bus(1'b1, `PSD_OFS_SHUTDOWN, 8'h11);
        bus(1'b0, `PSD_OFS_SHUTDOWN, 8'h00);
        chk(q, 8'h11);
        look(4'hA, 4'hF);
        restart();
        look(4'hF, 4'hF);
        bus(1'b1, `PSD_OFS_SHUTDOWN, 8'h84);
        look(4'h5, 4'hF);
        bus(1'b1, `PSD_OFS_SHUTDOWN, 8'h8E);
        look(4'h0, 4'h0);
        bus(1'b1, `PSD_OFS_SHUTDOWN, 8'h00);
        restart();
        for (int m = 0; m < 4; m++) begin
            mb = 2'(m);
            bus(1'b1, `PSD_OFS_MODE, 8'h0C | 8'(m));
            cyc(2);
            look({~mb[0], ~mb[1], ~mb[0], ~mb[1]}, 4'hF);
        end
        bus(1'b1, `PSD_OFS_MODE, 8'h08);
        cyc(2);
        look(4'h0, 4'h0);
        bus(1'b1, `PSD_OFS_MODE, 8'h0C);
        bus(1'b1, `PSD_OFS_STEER, 8'h01);
        cyc(2);
        look(4'h1, 4'h1);
        bus(1'b1, `PSD_OFS_SHUTDOWN, 8'h81);
        look(4'h0, 4'h1);
        bus(1'b1, `PSD_OFS_SHUTDOWN, 8'h00);
        restart();
        bus(1'b1, `PSD_OFS_STEER, 8'h12);
        cyc(3);
        look(4'h1, 4'h1);
        restart();
        look(4'h2, 4'h2);
        for (int p = 1; p < 4; p++) begin
            bus(1'b1, `PSD_OFS_STEER, {2'(p), 6'h00});
            cyc(2);
            look(4'h1, 4'h1 | (4'h1 << p));
        end
        bus(1'b1, `PSD_OFS_STEER, 8'h01);
        // half bridge: only the rising edge of pin a is pushed back
        bus(1'b1, `PSD_OFS_MODE, 8'h8C);
        pwm <= 1'b0;
        cyc(12);
        edge_time(1'b1, dr0);
        cyc(8);
        edge_time(1'b0, df0);
        bus(1'b1, `PSD_OFS_DEADBAND, 8'h03);
        cyc(12);
        edge_time(1'b1, dr3);
        cyc(8);
        edge_time(1'b0, df3);
        chk(8'(dr3 - dr0), 8'h03);
        chk(8'(df3), 8'(df0));
        bus(1'b1, `PSD_OFS_DEADBAND, 8'h0A);
        cyc(12);
        @(posedge clk) pwm <= 1'b1;
        repeat (6) begin
            @(posedge clk);
            #1;
            chk({7'h0, lvl[0]}, 8'h00);
        end
        @(posedge clk) pwm <= 1'b0;
        cyc(4);
        wrap_up();
    end
endmodule
